/* File: sdpc_pkg.sv */
// Purpose: shared constants and carriers for the shutdown and power-cycle controller
// Assumes: 10 MHz ref_clk, 16-bit register words, register port at documented indices
// Notes:   long hold counts are overridable at the top module
package sdpc_pkg;

  localparam int unsigned CLK_HZ          = 10000000;
  localparam int unsigned PWROFF_HOLD_MS  = 5;
  localparam int unsigned ON_HOLD_LONG_S  = 10;
  localparam int unsigned ON_HOLD_SHORT_S = 5;
  localparam int unsigned RETRY_GAP_MS    = 200;
  localparam int unsigned PWROFF_CYC      = (CLK_HZ / 1000) * PWROFF_HOLD_MS;
  localparam int unsigned ON_LONG_CYC     = CLK_HZ * ON_HOLD_LONG_S;
  localparam int unsigned ON_SHORT_CYC    = CLK_HZ * ON_HOLD_SHORT_S;
  localparam int unsigned RETRY_GAP_CYC   = (CLK_HZ / 1000) * RETRY_GAP_MS;
  localparam int unsigned MAX_ATTEMPTS    = 8;
  localparam int unsigned WDOG_FAULTS     = 7;

  localparam logic [7:0] ADDR_CTRL_ONE = 8'h03;
  localparam logic [7:0] ADDR_HIB_CTRL = 8'h05;

  localparam int unsigned BIT_SYSTEM_ON     = 15;
  localparam int unsigned BIT_RESTART_FAULT = 13;
  localparam int unsigned BIT_ON_DEBOUNCE   = 3;
  localparam int unsigned BIT_ON_POLARITY   = 1;
  localparam int unsigned BIT_HIB_REG_RESET = 5;

  localparam logic [15:0] CTRL_ONE_RESET = 16'h0002;
  localparam logic [15:0] HIB_CTRL_RESET = 16'h0000;
  localparam logic [15:0] CTRL_ONE_WMASK = 16'h200a;
  localparam logic [15:0] HIB_CTRL_WMASK = 16'h0020;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_STARTUP,
    ST_ACTIVE,
    ST_HIBERNATE,
    ST_SHUTDOWN,
    ST_RETRY_WAIT
  } power_state_e;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic        sw_off;
    logic        gpio_off;
    logic        on_pin;
    logic        wdog;
    logic        fault;
    logic        thermal;
  } shutdown_events_s;

endpackage : sdpc_pkg

/* File: hold_detect.sv */
// Purpose: flags a level held active for longer than a cycle threshold
// Assumes: input synchronous to ref_clk
// Notes:   one-cycle pulse per held press; re-arms once the level drops
`timescale 1ns/100ps
module hold_detect #(
  parameter int unsigned CW = 27
) (
  // clock and reset
  input  wire logic          ref_clk,
  input  wire logic          reset_n,
  // level and threshold
  input  wire logic          level_in,
  input  wire logic          active_low,
  input  wire logic [CW-1:0] limit,
  // result
  output logic               held_pulse
);
  initial begin
    if (CW < 2 || CW > 31) $error("hold_detect: CW out of range");
  end

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          fired;
    logic          pulse;
  } hd_s;

  hd_s st_reg;
  hd_s st_next;

  always_comb begin
    logic act;
    act = level_in ^ active_low;
    st_next = st_reg;
    st_next.pulse = 1'b0;
    if (!act) begin
      st_next.cnt   = '0;
      st_next.fired = 1'b0;
    end else if (!st_reg.fired) begin
      if (st_reg.cnt >= limit) begin
        st_next.fired = 1'b1;
        st_next.pulse = 1'b1;
      end else begin
        st_next.cnt = st_reg.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign held_pulse = st_reg.pulse;
endmodule : hold_detect

/* File: retry_counter.sv */
// Purpose: counts restart attempts and paces them
// Assumes: start pulses come only from the controller
// Notes:   done pulses after the gap expires
`timescale 1ns/100ps
module retry_counter #(
  parameter int unsigned GAP_CYC = sdpc_pkg::RETRY_GAP_CYC,
  parameter int unsigned MAX     = sdpc_pkg::MAX_ATTEMPTS
) (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  // control
  input  wire logic       start_gap,
  input  wire logic       clear,
  // status
  output logic            gap_done,
  output logic            exhausted,
  output logic [3:0]      attempts
);
  initial begin
    if (GAP_CYC < 1 || GAP_CYC > 2**24 || MAX < 1 || MAX > 15) $error("retry_counter: bad parameters");
  end

  typedef struct packed {
    logic [23:0] gap;
    logic        run;
    logic        done;
    logic [3:0]  n;
  } rc_s;

  rc_s st_reg;
  rc_s st_next;

  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    if (clear) begin
      st_next = '0;
    end else if (start_gap) begin
      st_next.run = 1'b1;
      st_next.gap = '0;
      st_next.n   = st_reg.n + 4'h1;
    end else if (st_reg.run) begin
      if (st_reg.gap >= 24'(GAP_CYC - 1)) begin
        st_next.run  = 1'b0;
        st_next.done = 1'b1;
      end else begin
        st_next.gap = st_reg.gap + 24'h000001;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign gap_done  = st_reg.done;
  assign exhausted = (st_reg.n >= 4'(MAX));
  assign attempts  = st_reg.n;
endmodule : retry_counter

/* File: shutdown_restart_on_fault_enable_ctrl.sv */
// Purpose: power state machine for shutdown events, register reset and restart on fault
// Assumes: all inputs synchronous to ref_clk; register port is a simple word port
// Notes:   start-up sequencing is outside; this block requests it and waits for its done
//
// Behaviour
// - any shutdown event moves active or hibernate to off, or to retry wait for a fault that is retried
// - writing zero to system-on bit 15 commands software shutdown
// - power-off gpio input held active over 5 ms is a shutdown event
// - on pin held active beyond debounce time is a shutdown event, default 10 s
// - debounce select bit 3 picks 10 s at zero, 5 s at one
// - on pin polarity bit 1: zero active high, one active low, resets one
// - watchdog timeout shuts down only after seven earlier recorded faults
// - faults programmed for shutdown and thermal shutdown are shutdown events
// - start-up sequence sets the system-on bit to one
// - shutdown asserts resets, resets registers unless retrying, disables functions, clears system-on
// - from off, any valid start-up event restarts the device
// - undervoltage or limit-switch overcurrent fault invokes the power-cycle decision
// - restart-on-fault bit 13 at zero: a qualifying fault goes to off
// - restart-on-fault at one: restart, at most 8 attempts spaced 200 ms
// - after eight failed attempts enter off and clear the attempt counter
// - control registers reset on entry to off
// - hibernate bit 5 zero resets control register one, except system-on, on hibernate exit, one suppresses
// - development mode may disable register reset on entry to off
// - host reset stays asserted low throughout off
`timescale 1ns/100ps
module shutdown_restart_on_fault_enable_ctrl #(
  parameter int unsigned PWROFF_CYC    = sdpc_pkg::PWROFF_CYC,
  parameter int unsigned ON_LONG_CYC   = sdpc_pkg::ON_LONG_CYC,
  parameter int unsigned ON_SHORT_CYC  = sdpc_pkg::ON_SHORT_CYC,
  parameter int unsigned RETRY_GAP_CYC = sdpc_pkg::RETRY_GAP_CYC
) (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  // register port
  input  wire sdpc_pkg::reg_req_s reg_req,
  output logic [15:0]            reg_rdata,
  // event inputs
  input  wire logic              on_pin,
  input  wire logic              gpio_power_off_input,
  input  wire logic              gpio_power_off_active_low,
  input  wire logic              watchdog_timeout,
  input  wire logic              supply_fault_shutdown,
  input  wire logic              thermal_shutdown,
  input  wire logic [2:0]        recorded_fault_count,
  // start-up and hibernate handshake
  input  wire logic              startup_event,
  input  wire logic              startup_done,
  input  wire logic              hibernate_enter,
  input  wire logic              hibernate_exit,
  input  wire logic              development_mode,
  input  wire logic              off_reset_disable,
  // outputs
  output logic                   host_reset_n,
  output logic                   memory_reset_n,
  output logic                   startup_request,
  output logic                   functions_enable,
  output logic                   control_reg_reset,
  output logic [2:0]             power_state,
  output logic [3:0]             attempt_count
);
  initial begin
    if (ON_SHORT_CYC > ON_LONG_CYC || ON_LONG_CYC >= 2**27 || PWROFF_CYC >= 2**27 || PWROFF_CYC < 1)
      $error("shutdown_restart_on_fault_enable_ctrl: bad hold counts");
  end

  typedef struct packed {
    sdpc_pkg::power_state_e state;
    logic [15:0]            ctrl_one;
    logic [15:0]            hib_ctrl;
    logic [15:0]            rdata;
    logic                   fault_retry;
    logic                   host_rst_n;
    logic                   mem_rst_n;
    logic                   start_req;
    logic                   func_en;
    logic                   reg_rst;
    logic                   gap_start;
    logic                   ctr_clear;
  } ctrl_s;

  ctrl_s st_reg;
  ctrl_s st_next;

  logic        on_held;
  logic        off_held;
  logic        gap_done;
  logic        exhausted;
  logic [3:0]  attempts;
  logic [26:0] on_limit;

  function automatic logic [15:0] reg_read(input logic [7:0] a, input ctrl_s s);
    if (a == sdpc_pkg::ADDR_CTRL_ONE) begin
      return s.ctrl_one;
    end else if (a == sdpc_pkg::ADDR_HIB_CTRL) begin
      return s.hib_ctrl;
    end
    return 16'h0000;
  endfunction : reg_read

  assign on_limit = st_reg.ctrl_one[sdpc_pkg::BIT_ON_DEBOUNCE] ? 27'(ON_SHORT_CYC - 1)
                                                                : 27'(ON_LONG_CYC - 1);

  hold_detect #(
    .CW(27)
  ) u_on_hold (
    .ref_clk    (ref_clk),
    .reset_n    (reset_n),
    .level_in   (on_pin),
    .active_low (st_reg.ctrl_one[sdpc_pkg::BIT_ON_POLARITY]),
    .limit      (on_limit),
    .held_pulse (on_held)
  );

  hold_detect #(
    .CW(27)
  ) u_off_hold (
    .ref_clk    (ref_clk),
    .reset_n    (reset_n),
    .level_in   (gpio_power_off_input),
    .active_low (gpio_power_off_active_low),
    .limit      (27'(PWROFF_CYC)),
    .held_pulse (off_held)
  );

  retry_counter #(
    .GAP_CYC(RETRY_GAP_CYC),
    .MAX    (sdpc_pkg::MAX_ATTEMPTS)
  ) u_retry (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .start_gap (st_reg.gap_start),
    .clear     (st_reg.ctr_clear),
    .gap_done  (gap_done),
    .exhausted (exhausted),
    .attempts  (attempts)
  );

  always_comb begin
    sdpc_pkg::shutdown_events_s ev;
    logic running;
    logic any_ev;
    logic do_reg_reset;
    ev = '0;
    running = 1'b0;
    any_ev = 1'b0;
    do_reg_reset = 1'b0;
    st_next = st_reg;
    st_next.reg_rst   = 1'b0;
    st_next.gap_start = 1'b0;
    st_next.ctr_clear = 1'b0;

    // register writes, only writable fields change
    if (reg_req.wr) begin
      if (reg_req.addr == sdpc_pkg::ADDR_CTRL_ONE) begin
        st_next.ctrl_one = (st_reg.ctrl_one & ~sdpc_pkg::CTRL_ONE_WMASK)
                         | (reg_req.wdata & sdpc_pkg::CTRL_ONE_WMASK);
      end else if (reg_req.addr == sdpc_pkg::ADDR_HIB_CTRL) begin
        st_next.hib_ctrl = (st_reg.hib_ctrl & ~sdpc_pkg::HIB_CTRL_WMASK)
                         | (reg_req.wdata & sdpc_pkg::HIB_CTRL_WMASK);
      end
    end
    if (reg_req.rd) begin
      st_next.rdata = reg_read(reg_req.addr, st_reg);
    end

    running = (st_reg.state == sdpc_pkg::ST_ACTIVE) || (st_reg.state == sdpc_pkg::ST_HIBERNATE);
    ev.sw_off   = reg_req.wr && reg_req.addr == sdpc_pkg::ADDR_CTRL_ONE
                  && !reg_req.wdata[sdpc_pkg::BIT_SYSTEM_ON];
    ev.gpio_off = off_held;
    ev.on_pin   = on_held;
    ev.wdog     = watchdog_timeout && recorded_fault_count >= 3'(sdpc_pkg::WDOG_FAULTS);
    ev.fault    = supply_fault_shutdown;
    ev.thermal  = thermal_shutdown;
    any_ev = |ev;

    unique case (st_reg.state)
      sdpc_pkg::ST_OFF: begin
        st_next.host_rst_n = 1'b0;
        st_next.mem_rst_n  = 1'b0;
        st_next.func_en    = 1'b0;
        if (startup_event) begin
          st_next.state     = sdpc_pkg::ST_STARTUP;
          st_next.start_req = 1'b1;
        end
      end
      sdpc_pkg::ST_STARTUP: begin
        st_next.start_req = 1'b0;
        if (supply_fault_shutdown || thermal_shutdown) begin
          st_next.fault_retry = supply_fault_shutdown;
          st_next.state       = sdpc_pkg::ST_SHUTDOWN;
        end else if (startup_done) begin
          st_next.state = sdpc_pkg::ST_ACTIVE;
          st_next.ctrl_one[sdpc_pkg::BIT_SYSTEM_ON] = 1'b1;
          st_next.func_en    = 1'b1;
          st_next.host_rst_n = 1'b1;
          st_next.mem_rst_n  = 1'b1;
          st_next.ctr_clear  = 1'b1;
        end
      end
      sdpc_pkg::ST_ACTIVE, sdpc_pkg::ST_HIBERNATE: begin
        if (any_ev && running) begin
          st_next.fault_retry = ev.fault && !ev.sw_off && !ev.gpio_off && !ev.on_pin;
          st_next.state       = sdpc_pkg::ST_SHUTDOWN;
        end else if (st_reg.state == sdpc_pkg::ST_ACTIVE && hibernate_enter) begin
          st_next.state = sdpc_pkg::ST_HIBERNATE;
        end else if (st_reg.state == sdpc_pkg::ST_HIBERNATE && hibernate_exit) begin
          st_next.state = sdpc_pkg::ST_ACTIVE;
          if (!st_reg.hib_ctrl[sdpc_pkg::BIT_HIB_REG_RESET]) begin
            st_next.reg_rst  = 1'b1;
            st_next.ctrl_one = (sdpc_pkg::CTRL_ONE_RESET & ~16'h8000) | (st_reg.ctrl_one & 16'h8000);
          end
        end
      end
      sdpc_pkg::ST_SHUTDOWN: begin
        // further events here are absorbed into this one sequence
        st_next.host_rst_n = 1'b0;
        st_next.mem_rst_n  = 1'b0;
        st_next.func_en    = 1'b0;
        st_next.ctrl_one[sdpc_pkg::BIT_SYSTEM_ON] = 1'b0;
        do_reg_reset = !(development_mode && off_reset_disable);
        if (st_reg.fault_retry && st_reg.ctrl_one[sdpc_pkg::BIT_RESTART_FAULT] && !exhausted) begin
          st_next.state     = sdpc_pkg::ST_RETRY_WAIT;
          st_next.gap_start = 1'b1;
          do_reg_reset      = 1'b0;
        end else begin
          st_next.state     = sdpc_pkg::ST_OFF;
          st_next.ctr_clear = 1'b1;
        end
        if (do_reg_reset) begin
          st_next.reg_rst  = 1'b1;
          st_next.ctrl_one = sdpc_pkg::CTRL_ONE_RESET;
          st_next.hib_ctrl = sdpc_pkg::HIB_CTRL_RESET;
        end
        st_next.fault_retry = 1'b0;
      end
      sdpc_pkg::ST_RETRY_WAIT: begin
        if (gap_done) begin
          st_next.state     = sdpc_pkg::ST_STARTUP;
          st_next.start_req = 1'b1;
        end
      end
      default: begin
        st_next.state = sdpc_pkg::ST_OFF;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      st_reg          <= '0;
      st_reg.state    <= sdpc_pkg::ST_OFF;
      st_reg.ctrl_one <= sdpc_pkg::CTRL_ONE_RESET;
      st_reg.hib_ctrl <= sdpc_pkg::HIB_CTRL_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata         = st_reg.rdata;
  assign host_reset_n      = st_reg.host_rst_n;
  assign memory_reset_n    = st_reg.mem_rst_n;
  assign startup_request   = st_reg.start_req;
  assign functions_enable  = st_reg.func_en;
  assign control_reg_reset = st_reg.reg_rst;
  assign power_state       = st_reg.state;
  assign attempt_count     = attempts;
endmodule : shutdown_restart_on_fault_enable_ctrl

/* File: sdpc_checker.sv */
// Purpose: port-level assertions for the shutdown and power-cycle controller
// Assumes: state codes as in sdpc_pkg::power_state_e
// Notes:   bound into every controller instance
`timescale 1ns/100ps
module sdpc_checker #(
  parameter int unsigned RETRY_GAP_CYC = 30
) (
  // clock and reset
  input wire logic               ref_clk,
  input wire logic               reset_n,
  // inputs watched
  input wire sdpc_pkg::reg_req_s reg_req,
  input wire logic               watchdog_timeout,
  input wire logic               thermal_shutdown,
  input wire logic [2:0]         recorded_fault_count,
  input wire logic               startup_event,
  input wire logic               startup_done,
  input wire logic               development_mode,
  input wire logic               off_reset_disable,
  // outputs watched
  input wire logic               host_reset_n,
  input wire logic               memory_reset_n,
  input wire logic               startup_request,
  input wire logic               functions_enable,
  input wire logic               control_reg_reset,
  input wire logic [2:0]         power_state,
  input wire logic [3:0]         attempt_count
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic [31:0] gap_cnt;
  // cycles spent so far in the retry wait
  always_ff @(posedge ref_clk) begin
    if (!reset_n || power_state != 3'h5)
      gap_cnt <= '0;
    else
      gap_cnt <= gap_cnt + 32'h1;
  end
  sequence shut_to_off;
    power_state == 3'h4 ##1 power_state == 3'h0;
  endsequence
  sequence sw_off_cmd;
    reg_req.wr && reg_req.addr == 8'h03 && !reg_req.wdata[15] && power_state inside {3'h2, 3'h3};
  endsequence
  off_holds_reset_a: assert property (
    power_state == 3'h0 |-> !host_reset_n) else $error("host reset released in off");
  sw_shutdown_a: assert property (
    sw_off_cmd |=> shut_to_off) else $error("software shutdown not taken");
  thermal_off_a: assert property (
    thermal_shutdown && power_state inside {3'h2, 3'h3} |=> power_state == 3'h4) else $error("thermal ignored");
  wdog_off_a: assert property (
    watchdog_timeout && recorded_fault_count == 3'h7 && power_state == 3'h2 |=> power_state == 3'h4)
    else $error("watchdog ignored");
  shut_outputs_a: assert property (
    shut_to_off |-> !memory_reset_n && !host_reset_n && !functions_enable) else $error("off outputs wrong");
  off_reg_reset_a: assert property (
    shut_to_off ##0 !(development_mode && off_reset_disable) |-> control_reg_reset)
    else $error("no register reset in off");
  start_req_a: assert property (
    startup_event && power_state == 3'h0 |=> power_state == 3'h1 && startup_request) else $error("no start");
  up_active_a: assert property (
    power_state == 3'h1 && startup_done |=> power_state == 3'h2 && host_reset_n && functions_enable)
    else $error("start-up not completed");
  retry_gap_a: assert property (
    $fell(power_state == 3'h5) |-> power_state == 3'h1 && $past(gap_cnt) + 32'h1 >= RETRY_GAP_CYC
    && $past(gap_cnt) <= RETRY_GAP_CYC + 1) else $error("retry spacing wrong");
  count_clear_a: assert property (
    $rose(power_state == 3'h0) |=> attempt_count == 4'h0) else $error("attempts not cleared");
  single_shut_a: assert property (
    power_state == 3'h4 |=> power_state != 3'h4) else $error("shutdown repeated");
endmodule : sdpc_checker
bind shutdown_restart_on_fault_enable_ctrl sdpc_checker #(.RETRY_GAP_CYC(RETRY_GAP_CYC)) sdpc_checker_i (.*);

/* File: sdpc_partner.sv */
// Purpose: start-up sequencer and supply fault monitor beside the controller
// Assumes: startup_request is a one-cycle pulse
// Notes:   fail_start makes every start-up end in a supply fault
`timescale 1ns/100ps
module sdpc_partner #(
  parameter int unsigned DONE_DLY = 4
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // bench commands
  input wire logic fail_start,
  input wire logic kick_fault,
  // controller side
  input wire logic startup_request,
  output logic     startup_done,
  output logic     supply_fault_shutdown
);
  logic [3:0] dly;
  logic       busy;
  always_ff @(posedge ref_clk) begin
    startup_done <= 1'b0;
    supply_fault_shutdown <= kick_fault;
    if (!reset_n) begin
      busy <= 1'b0;
      dly <= '0;
    end else if (startup_request) begin
      busy <= 1'b1;
      dly <= '0;
    end else if (busy && dly == DONE_DLY[3:0]) begin
      busy <= 1'b0;
      startup_done <= !fail_start;
      supply_fault_shutdown <= fail_start;
    end else if (busy) begin
      dly <= dly + 4'h1;
    end
  end
endmodule : sdpc_partner

/* File: tb_shutdown_restart_on_fault_enable_ctrl.sv */
// Purpose: directed scenarios for the shutdown and power-cycle controller
// Assumes: shortened hold and gap counts
// Notes:   inputs change 1 ns after the rising edge
`timescale 1ns/100ps
module tb_shutdown_restart_on_fault_enable_ctrl;
  localparam int unsigned PO = 10, OL = 40, OS = 20, GAP = 30;
  localparam logic [7:0] A1 = sdpc_pkg::ADDR_CTRL_ONE, A5 = sdpc_pkg::ADDR_HIB_CTRL;
  logic ref_clk, reset_n, on_pin, gpio_power_off_input, gpio_power_off_active_low, watchdog_timeout;
  logic supply_fault_shutdown, thermal_shutdown, startup_event, startup_done, hibernate_enter;
  logic hibernate_exit, development_mode, off_reset_disable, fail_start, kick_fault;
  logic host_reset_n, memory_reset_n, startup_request, functions_enable, control_reg_reset;
  logic [2:0]         recorded_fault_count, power_state;
  logic [3:0]         attempt_count, m;
  logic [15:0]        reg_rdata, rv;
  sdpc_pkg::reg_req_s reg_req;
  int                 failures = 0, n_compared = 0, n;
  shutdown_restart_on_fault_enable_ctrl #(.PWROFF_CYC(PO), .ON_LONG_CYC(OL), .ON_SHORT_CYC(OS), .RETRY_GAP_CYC(GAP))
    shutdown_restart_on_fault_enable_ctrl_i (.*);
  sdpc_partner sdpc_partner_i (.ref_clk(ref_clk), .reset_n(reset_n), .fail_start(fail_start),
    .kick_fault(kick_fault), .startup_request(startup_request), .startup_done(startup_done),
    .supply_fault_shutdown(supply_fault_shutdown));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic end_sim;
    $display("compared %0d mismatched %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    tick(1);
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    tick(1);
    reg_req.wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    tick(1);
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    tick(1);
    reg_req.rd = 1'b0;
    rv = reg_rdata;
  endtask : rd
  task automatic wait_st(input logic [2:0] s, input int lim);
    n = 0;
    while (power_state !== s && n < lim) begin
      tick(1);
      n++;
    end
    chk(power_state, s, "state reached");
  endtask : wait_st
  task automatic power_up;
    tick(1);
    startup_event = 1'b1;
    tick(1);
    startup_event = 1'b0;
    wait_st(3'h2, 50);
    rd(A1);
    chk(rv[15], 1'b1, "system on after start");
  endtask : power_up
  task automatic t_regs;
    rd(A1);
    chk(rv, 16'h0002, "ctrl reset value");
    rd(A5);
    chk(rv, 16'h0000, "hib reset value");
    power_up;
    wr(A1, 16'hffff);
    rd(A1);
    chk(rv, 16'ha00a, "writable bits");
    rd(8'h04);
    chk(rv, 16'h0000, "unmapped read");
    wr(A1, 16'h0000);
    wait_st(3'h0, 5);
    rd(A1);
    chk(rv, 16'h0002, "ctrl reset in off");
    $display("registers and software off done");
  endtask : t_regs
  task automatic t_on(input logic [15:0] cfg, input logic act, input int lim);
    power_up;
    wr(A1, cfg);
    on_pin = act;
    wait_st(3'h4, lim + 8);
    chk(n >= lim && n <= lim + 3, 1'b1, "on pin hold time");
    on_pin = 1'b1;
    wait_st(3'h0, 4);
    $display("on pin hold %0d done", lim);
  endtask : t_on
  task automatic t_misc;
    power_up;
    gpio_power_off_input = 1'b1;
    tick(PO);
    gpio_power_off_input = 1'b0;
    tick(3);
    chk(power_state, 3'h2, "short gpio ignored");
    gpio_power_off_input = 1'b1;
    wait_st(3'h4, PO + 8);
    chk(n >= PO && n <= PO + 3, 1'b1, "gpio hold time");
    gpio_power_off_input = 1'b0;
    power_up;
    recorded_fault_count = 3'h6;
    watchdog_timeout = 1'b1;
    tick(1);
    watchdog_timeout = 1'b0;
    tick(3);
    chk(power_state, 3'h2, "watchdog under seven");
    recorded_fault_count = 3'h7;
    watchdog_timeout = 1'b1;
    thermal_shutdown = 1'b1;
    tick(1);
    watchdog_timeout = 1'b0;
    wait_st(3'h0, 5);
    thermal_shutdown = 1'b0;
    recorded_fault_count = 3'h0;
    power_up;
    gpio_power_off_active_low = 1'b1;
    wait_st(3'h4, PO + 8);
    chk(n >= PO && n <= PO + 3, 1'b1, "active low gpio hold time");
    gpio_power_off_input = 1'b1;
    $display("gpio and watchdog done");
  endtask : t_misc
  task automatic t_retry;
    fail_start = 1'b1;
    tick(1);
    startup_event = 1'b1;
    tick(1);
    startup_event = 1'b0;
    wait_st(3'h0, 20);
    chk(attempt_count, 4'h0, "no retry at bit clear");
    fail_start = 1'b0;
    power_up;
    wr(A1, 16'ha002);
    fail_start = 1'b1;
    kick_fault = 1'b1;
    tick(1);
    kick_fault = 1'b0;
    m = 4'h0;
    for (n = 0; n < 2000 && power_state !== 3'h0; n++) begin
      tick(1);
      if (attempt_count > m) m = attempt_count;
    end
    chk(m, 4'h8, "attempts made");
    chk(power_state, 3'h0, "off after attempts");
    fail_start = 1'b0;
    $display("power cycling done");
  endtask : t_retry
  task automatic hib_cycle(input logic [15:0] hib, input logic [15:0] exp);
    wr(A5, hib);
    wr(A1, 16'h800a);
    hibernate_enter = 1'b1;
    tick(1);
    hibernate_enter = 1'b0;
    wait_st(3'h3, 5);
    hibernate_exit = 1'b1;
    tick(1);
    hibernate_exit = 1'b0;
    wait_st(3'h2, 50);
    rd(A1);
    chk(rv, exp, "ctrl after hibernate exit");
  endtask : hib_cycle
  task automatic t_hib;
    power_up;
    hib_cycle(16'h0000, 16'h8002);
    hib_cycle(16'h0020, 16'h800a);
    hibernate_enter = 1'b1;
    tick(1);
    hibernate_enter = 1'b0;
    wait_st(3'h3, 5);
    thermal_shutdown = 1'b1;
    wait_st(3'h0, 5);
    thermal_shutdown = 1'b0;
    development_mode = 1'b1;
    off_reset_disable = 1'b1;
    power_up;
    wr(A1, 16'ha002);
    wr(A1, 16'h2002);
    wait_st(3'h0, 5);
    rd(A1);
    chk(rv, 16'h2002, "register reset disabled");
    $display("hibernate and development done");
  endtask : t_hib
  initial begin
    {reset_n, gpio_power_off_input, gpio_power_off_active_low, watchdog_timeout, thermal_shutdown} = '0;
    {startup_event, hibernate_enter, hibernate_exit, development_mode, off_reset_disable} = '0;
    {fail_start, kick_fault, recorded_fault_count} = '0;
    reg_req = '0;
    on_pin = 1'b1;
    tick(8);
    reset_n = 1'b1;
    t_regs;
    t_on(16'h8002, 1'b0, OL);
    t_on(16'h8008, 1'b1, OS);
    t_misc;
    t_retry;
    t_hib;
    end_sim;
  end
  initial begin
    #1000000;
    failures++;
    end_sim;
  end
endmodule : tb_shutdown_restart_on_fault_enable_ctrl
